//--- hw/dma_desc_consts.svh
`ifndef DMA_DESC_CONSTS_SVH
`define DMA_DESC_CONSTS_SVH

// ----------------------------------------------------------------------------
// register offsets (byte addresses, one word each)
// ----------------------------------------------------------------------------
`define OFF_SRC_END    12'h000
`define OFF_DST_END    12'h004
`define OFF_CTRL       12'h008
`define OFF_TBL_BASE   12'h00C
`define OFF_CHAN_SEL   12'h010
`define OFF_ITEM_LEFT  12'h014
`define OFF_CUR_SRC    12'h018
`define OFF_CUR_DST    12'h01C
`define OFF_DESC_ADDR  12'h020
`define OFF_STATUS     12'h024

// ----------------------------------------------------------------------------
// descriptor layout in system memory
// ----------------------------------------------------------------------------
`define WORD_SRC_END   32'h0000_0000
`define WORD_DST_END   32'h0000_0004
`define WORD_CTRL      32'h0000_0008
`define DESC_STRIDE    32'h0000_0010
`define ALT_OFFSET     32'h0000_0200

// ----------------------------------------------------------------------------
// control word field positions
// ----------------------------------------------------------------------------
`define DST_STEP_HI    31
`define DST_STEP_LO    30
`define DST_WIDTH_HI   29
`define DST_WIDTH_LO   28
`define SRC_STEP_HI    27
`define SRC_STEP_LO    26
`define SRC_WIDTH_HI   25
`define SRC_WIDTH_LO   24

// ----------------------------------------------------------------------------
// channel select and status fields
// ----------------------------------------------------------------------------
`define SEL_ALT_BIT    8
`define ST_SRC_UNREAD  0
`define ST_WIDTH_MIS   1
`define ST_STEP_SMALL  2
`define ST_WIDTH_RSVD  3
`define RESET_WORD     32'h0000_0000

`endif

//--- hw/dma_desc_pkg.sv
package dma_desc_pkg;

  // address step codes, in field order
  typedef enum logic [1:0] {
    STEP_BYTE,
    STEP_HALF,
    STEP_WORD,
    STEP_NONE
  } step_t;

  // item width codes, in field order
  typedef enum logic [1:0] {
    WIDTH_8,
    WIDTH_16,
    WIDTH_32,
    WIDTH_RSVD
  } width_t;

  // decoded control word
  typedef struct packed {
    step_t  dst_step;
    width_t dst_width;
    step_t  src_step;
    width_t src_width;
  } decode_t;

endpackage : dma_desc_pkg

//--- hw/dma_channel_descriptor_decode.sv
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "dma_desc_consts.svh"

module dma_channel_descriptor_decode
  import dma_desc_pkg::*;
#(
  parameter int          CHANNELS  = 32,
  parameter int          CNT_W     = 10,
  parameter logic [31:0] SRAM_BASE = 32'h2000_0000
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // descriptor fetch addresses
  output logic [31:0]      src_word_addr,
  output logic [31:0]      dst_word_addr,
  output logic [31:0]      ctl_word_addr,
  // current item addresses and decode
  output logic [31:0]      cur_src_addr,
  output logic [31:0]      cur_dst_addr,
  output logic [1:0]       item_width,
  output logic [3:0]       cfg_fault
);

  localparam int SEL_W = $clog2(CHANNELS);

  // elaboration check: the select field holds at most 5 bits, the count at most 16
  if (CHANNELS < 2 || CHANNELS > 32 || CNT_W < 1 || CNT_W > 16) begin : g_bad_params
    $error("unsupported channel count or item counter width");
  end

  // --------------------------------------------------------------------------
  // item address from inclusive end and remaining count
  // --------------------------------------------------------------------------
  function automatic logic [31:0] item_addr(input logic [31:0]    end_a,
                                            input step_t          step,
                                            input logic [CNT_W-1:0] left);
    logic [31:0] span;
    span = 32'(left) << step;
    // a fixed step never moves, whatever the remaining count says
    return (step == STEP_NONE) ? end_a : end_a - span;
  endfunction : item_addr

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  logic [31:0]      src_end_q;
  logic [31:0]      dst_end_q;
  logic [31:0]      ctrl_q;
  logic [31:0]      tbl_base_q;
  logic [SEL_W-1:0] chan_q;
  logic             alt_q;
  logic [CNT_W-1:0] left_q;
  logic             pready_q;
  logic [31:0]      prdata_q;
  logic             pslverr_q;
  logic [31:0]      src_word_q;
  logic [31:0]      dst_word_q;
  logic [31:0]      ctl_word_q;
  logic [31:0]      cur_src_q;
  logic [31:0]      cur_dst_q;
  logic [1:0]       width_q;
  logic [3:0]       fault_q;

  // --------------------------------------------------------------------------
  // apb decode
  // --------------------------------------------------------------------------
  // one wait state keeps read data and ready straight from flip-flops
  wire        access    = psel & penable;
  wire        take      = access & pready_q;
  wire        wr_take   = take & pwrite;
  wire        pready_d  = access & ~pready_q;
  wire        hit_src   = (paddr == `OFF_SRC_END);
  wire        hit_dst   = (paddr == `OFF_DST_END);
  wire        hit_ctrl  = (paddr == `OFF_CTRL);
  wire        hit_tbl   = (paddr == `OFF_TBL_BASE);
  wire        hit_sel   = (paddr == `OFF_CHAN_SEL);
  wire        hit_left  = (paddr == `OFF_ITEM_LEFT);
  wire        hit_ro    = (paddr == `OFF_CUR_SRC) | (paddr == `OFF_CUR_DST) |
                          (paddr == `OFF_DESC_ADDR) | (paddr == `OFF_STATUS);
  wire        hit_rw    = hit_src | hit_dst | hit_ctrl | hit_tbl | hit_sel | hit_left;
  wire        mapped    = hit_rw | hit_ro;
  // writes to read-only or unmapped words answer with an error
  wire        err_d     = pready_d & ~(mapped & ~(pwrite & hit_ro));

  // --------------------------------------------------------------------------
  // control word decode
  // --------------------------------------------------------------------------
  decode_t dec;
  assign dec.dst_step  = step_t'(ctrl_q[`DST_STEP_HI:`DST_STEP_LO]);
  assign dec.dst_width = width_t'(ctrl_q[`DST_WIDTH_HI:`DST_WIDTH_LO]);
  assign dec.src_step  = step_t'(ctrl_q[`SRC_STEP_HI:`SRC_STEP_LO]);
  assign dec.src_width = width_t'(ctrl_q[`SRC_WIDTH_HI:`SRC_WIDTH_LO]);

  // source address; fixed step stays on the end address
  wire [31:0] cur_src_d = item_addr(src_end_q, dec.src_step, left_q);
  // destination address; fixed step stays on the end address
  wire [31:0] cur_dst_d = item_addr(dst_end_q, dec.dst_step, left_q);

  // structure base inside the table
  wire [31:0] desc_base = tbl_base_q + (alt_q ? `ALT_OFFSET : 32'h0000_0000) +
                          32'(chan_q) * `DESC_STRIDE;

  // configuration checks reported as status, they never stop the decode
  logic [3:0] fault_d;
  assign fault_d[`ST_SRC_UNREAD] = (src_end_q < SRAM_BASE);
  assign fault_d[`ST_WIDTH_MIS]  = (dec.dst_width != dec.src_width);
  // a reserved width code sits above every stepping code, so it raises this bit too
  assign fault_d[`ST_STEP_SMALL] =
    (dec.src_step != STEP_NONE && dec.src_step < dec.src_width) |
    (dec.dst_step != STEP_NONE && dec.dst_step < dec.dst_width);
  assign fault_d[`ST_WIDTH_RSVD] = (dec.src_width == WIDTH_RSVD) |
                                   (dec.dst_width == WIDTH_RSVD);

  // read mux; reserved control bits read back as stored
  // unmapped reads give zero so a stray read never leaks a stale word
  wire [31:0] rd_d =
    hit_src  ? src_end_q :
    hit_dst  ? dst_end_q :
    hit_ctrl ? ctrl_q :
    hit_tbl  ? tbl_base_q :
    hit_sel  ? (32'(alt_q) << `SEL_ALT_BIT) | 32'(chan_q) :
    hit_left ? 32'(left_q) :
    (paddr == `OFF_CUR_SRC)   ? cur_src_q :
    (paddr == `OFF_CUR_DST)   ? cur_dst_q :
    (paddr == `OFF_DESC_ADDR) ? src_word_q :
    (paddr == `OFF_STATUS)    ? 32'(fault_q) : `RESET_WORD;

  // --------------------------------------------------------------------------
  // apb answer
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pready_q  <= 1'b0;
      prdata_q  <= `RESET_WORD;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= pready_d;
      prdata_q  <= (pready_d & ~pwrite) ? rd_d : `RESET_WORD;
      pslverr_q <= err_d;
    end
  end

  // --------------------------------------------------------------------------
  // software registers, written only at the completing edge
  // --------------------------------------------------------------------------
  // select keeps its low bits and bit 8, count only its low bits; the rest of those words reads zero
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      src_end_q  <= `RESET_WORD;
      dst_end_q  <= `RESET_WORD;
      ctrl_q     <= `RESET_WORD;
      tbl_base_q <= `RESET_WORD;
      chan_q     <= '0;
      alt_q      <= 1'b0;
      left_q     <= '0;
    end else if (wr_take) begin
      if (hit_src)  src_end_q  <= pwdata;
      if (hit_dst)  dst_end_q  <= pwdata;
      if (hit_ctrl) ctrl_q     <= pwdata;
      if (hit_tbl)  tbl_base_q <= pwdata;
      if (hit_sel)  chan_q     <= pwdata[SEL_W-1:0];
      if (hit_sel)  alt_q      <= pwdata[`SEL_ALT_BIT];
      if (hit_left) left_q     <= pwdata[CNT_W-1:0];
    end
  end

  // --------------------------------------------------------------------------
  // decoded outputs, one cycle behind the registers
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      src_word_q <= `RESET_WORD;
      dst_word_q <= `RESET_WORD;
      ctl_word_q <= `RESET_WORD;
      cur_src_q  <= `RESET_WORD;
      cur_dst_q  <= `RESET_WORD;
      width_q    <= 2'h0;
      fault_q    <= 4'h0;
    end else begin
      src_word_q <= desc_base + `WORD_SRC_END;
      dst_word_q <= desc_base + `WORD_DST_END;
      ctl_word_q <= desc_base + `WORD_CTRL;
      cur_src_q  <= cur_src_d;
      cur_dst_q  <= cur_dst_d;
      width_q    <= dec.src_width;
      fault_q    <= fault_d;
    end
  end

  assign pready        = pready_q;
  assign prdata        = prdata_q;
  assign pslverr       = pslverr_q;
  assign src_word_addr = src_word_q;
  assign dst_word_addr = dst_word_q;
  assign ctl_word_addr = ctl_word_q;
  assign cur_src_addr  = cur_src_q;
  assign cur_dst_addr  = cur_dst_q;
  assign item_width    = width_q;
  assign cfg_fault     = fault_q;

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  src_fixed_a: assert property (ctrl_q[27:26] == 2'h3 |=> cur_src_q == $past(src_end_q))
    else $error("fixed source address moved off the end address");
  dst_fixed_a: assert property (ctrl_q[31:30] == 2'h3 |=> cur_dst_q == $past(dst_end_q))
    else $error("fixed destination address moved off the end address");
  src_last_a: assert property (left_q == '0 |=> cur_src_q == $past(src_end_q))
    else $error("last source item is not at the end address");
  dst_last_a: assert property (left_q == '0 |=> cur_dst_q == $past(dst_end_q))
    else $error("last destination item is not at the end address");
  src_word_a: assert property (ctrl_q[27:26] == 2'h2 |=>
      cur_src_q == $past(src_end_q) - ($past(32'(left_q)) << 2))
    else $error("word source step miscounted");
  dst_byte_a: assert property (ctrl_q[31:30] == 2'h0 |=>
      cur_dst_q == $past(dst_end_q) - $past(32'(left_q)))
    else $error("byte destination step miscounted");
  alt_base_a: assert property (alt_q |=>
      ctl_word_q == $past(tbl_base_q) + 32'h208 + $past(32'(chan_q)) * 32'h10)
    else $error("alternate control word address wrong");
  // the fetch words still hold their reset zeros at the first edge out of reset
  desc_words_a: assert property ($past(rst_b) |->
      dst_word_q == src_word_q + 32'h4 && ctl_word_q == src_word_q + 32'h8)
    else $error("descriptor word offsets wrong");
  rom_source_a: assert property (src_end_q < SRAM_BASE |=> cfg_fault[0])
    else $error("unreadable source not flagged");
  width_rsvd_a: assert property (ctrl_q[25:24] == 2'h3 |=>
      cfg_fault[3] && item_width == 2'h3)
    else $error("reserved source width not flagged");
  dst_rsvd_a: assert property (ctrl_q[29:28] == 2'h3 |=> cfg_fault[3])
    else $error("reserved destination width not flagged");

  // half-word stepping and the primary half of the table
  src_half_a: assert property (ctrl_q[27:26] == 2'h1 |=>
      cur_src_q == $past(src_end_q) - ($past(32'(left_q)) << 1))
    else $error("half-word source step miscounted");
  dst_half_a: assert property (ctrl_q[31:30] == 2'h1 |=>
      cur_dst_q == $past(dst_end_q) - ($past(32'(left_q)) << 1))
    else $error("half-word destination step miscounted");
  prim_base_a: assert property (!alt_q |=>
      src_word_q == $past(tbl_base_q) + $past(32'(chan_q)) * 32'h10)
    else $error("primary structure address wrong");

  // configuration faults are levels that follow the control word by one edge
  width_mis_a: assert property (ctrl_q[29:28] != ctrl_q[25:24] |=> cfg_fault[1])
    else $error("width mismatch not flagged");
  width_ok_a: assert property (ctrl_q[29:28] == ctrl_q[25:24] |=> !cfg_fault[1])
    else $error("matching widths flagged as a mismatch");
  step_small_a: assert property (ctrl_q[27:26] < ctrl_q[25:24] |=> cfg_fault[2])
    else $error("source step below item width not flagged");
  item_width_a: assert property (1'b1 |=> item_width == $past(ctrl_q[25:24]))
    else $error("item width does not follow the source width field");

  // software view of the bus
  apb_wait_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer not given after one wait state");
  ro_write_a: assert property (psel && penable && !pready && pwrite &&
      paddr == `OFF_CUR_SRC |=> pready && pslverr)
    else $error("write to a read-only word accepted");
  ctrl_keep_a: assert property (psel && penable && pready && pwrite &&
      paddr == `OFF_CTRL |=> ctrl_q == $past(pwdata))
    else $error("control word not stored whole");
  quiet_rdata_a: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data shown outside the answer cycle");

  fixed_src_c: cover property (ctrl_q[27:26] == 2'h3 && left_q != '0);
  alt_fetch_c: cover property (alt_q && chan_q != '0);
  fault_seen_c: cover property (cfg_fault != 4'h0 ##1 cfg_fault == 4'h0);
  half_step_c: cover property (ctrl_q[27:26] == 2'h1 && left_q != '0);
  ro_error_c: cover property (pready && pslverr);

endmodule : dma_channel_descriptor_decode

//--- tb/sys_mem_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// system memory holding descriptor words, one sram window
// ----------------------------------------------------------------------------
module sys_mem_model #(
  parameter logic [31:0] BASE = 32'h2000_0000
) (
  // clock
  input  wire logic        mclk,
  // software writes a descriptor word
  input  wire logic        wr_en,
  input  wire logic [31:0] wr_addr,
  input  wire logic [31:0] wr_data,
  // controller word reads
  input  wire logic [31:0] rd_addr_a,
  input  wire logic [31:0] rd_addr_b,
  input  wire logic [31:0] rd_addr_c,
  output logic      [31:0] rd_data_a,
  output logic      [31:0] rd_data_b,
  output logic      [31:0] rd_data_c
);
  logic [31:0] mem [1024];

  // flash and rom sit elsewhere: a changing pattern, never a stale word
  function automatic logic [31:0] look(input logic [31:0] a);
    if (a < BASE || a >= BASE + 32'h0000_1000) return ~a;
    return mem[10'((a - BASE) >> 2)];
  endfunction : look

  // word writes land on the rising edge
  always_ff @(posedge mclk) begin
    if (wr_en) mem[10'((wr_addr - BASE) >> 2)] <= wr_data;
  end

  // always_comb so a write to mem re-evaluates the reads
  always_comb begin
    rd_data_a = look(rd_addr_a);
    rd_data_b = look(rd_addr_b);
    rd_data_c = look(rd_addr_c);
  end
endmodule : sys_mem_model

//--- tb/dma_channel_descriptor_decode_tb_top.sv
`timescale 1ns/1ps
module dma_channel_descriptor_decode_tb_top;
  import dma_desc_pkg::*;
  // ----------------------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------------------
  localparam logic [31:0] TBL = 32'h2000_0400;
  localparam logic [31:0] SE  = 32'h2000_0100;
  localparam logic [31:0] DE  = 32'h2000_0800;
  logic        mclk, rst_b, psel, penable, pwrite, pready, pslverr, mem_wr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, src_word_addr, dst_word_addr, ctl_word_addr;
  logic [31:0] cur_src_addr, cur_dst_addr, mem_wa, mem_wd, m_a, m_b, m_c, es, ed;
  logic [1:0]  item_width;
  logic [3:0]  cfg_fault;
  int          n_fail, comparisons;

  dma_channel_descriptor_decode #(.CHANNELS(32), .CNT_W(10), .SRAM_BASE(32'h2000_0000))
    dma_channel_descriptor_decode_inst (.mclk(mclk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .src_word_addr(src_word_addr),
    .dst_word_addr(dst_word_addr), .ctl_word_addr(ctl_word_addr),
    .cur_src_addr(cur_src_addr), .cur_dst_addr(cur_dst_addr), .item_width(item_width),
    .cfg_fault(cfg_fault));
  sys_mem_model #(.BASE(32'h2000_0000)) sys_mem_model_inst (.mclk(mclk), .wr_en(mem_wr),
    .wr_addr(mem_wa), .wr_data(mem_wd), .rd_addr_a(src_word_addr),
    .rd_addr_b(dst_word_addr), .rd_addr_c(ctl_word_addr), .rd_data_a(m_a),
    .rd_data_b(m_b), .rd_data_c(m_c));

  // ----------------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------------
  task automatic ochk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : ochk

  // one apb transfer; waits for pready, never assumes the wait count
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] exp, input logic err);
    int n;
    @(posedge mclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge mclk); n++; end while (pready !== 1'b1 && n < 16);
    ochk(32'(pslverr), 32'(err));
    if (!w) ochk(prdata, exp);
    if (n >= 16) ochk(32'h0, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 1'b0);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, e, 1'b0);
  endtask : rd

  // decode outputs trail the register write by one edge
  task automatic settle();
    @(posedge mclk);
    #1;
  endtask : settle

  // software places a descriptor; write enable held across the three words
  task automatic put3(input logic [31:0] b, input logic [31:0] w0, w1, w2);
    logic [31:0] w [3];
    w = '{w0, w1, w2};
    for (int i = 0; i < 3; i++) begin
      mem_wr <= 1'b1; mem_wa <= b + 32'(4 * i); mem_wd <= w[i];
      @(posedge mclk);
    end
    mem_wr <= 1'b0;
    @(posedge mclk);
  endtask : put3

  function automatic logic [31:0] cw(input logic [1:0] ds, dw, ss, sw);
    return {ds, dw, ss, sw, 6'h2A, 18'h0};
  endfunction : cw

  task automatic give_verdict();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // watchdog: the tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge mclk);
    n_fail++;
    give_verdict();
  end

  initial begin
    n_fail = 0; comparisons = 0; rst_b = 1'b0; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0; mem_wr = 1'b0; mem_wa = 32'h0;
    mem_wd = 32'h0;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    rd(12'h024, 32'h0000_0001);
    wr(12'h00C, TBL);
    wr(12'h010, 32'h0000_0105);
    settle();
    ochk(src_word_addr, TBL + 32'h0000_0250);
    ochk(dst_word_addr, TBL + 32'h0000_0254);
    ochk(ctl_word_addr, TBL + 32'h0000_0258);
    rd(12'h020, TBL + 32'h0000_0250);
    wr(12'h010, 32'h0000_0003);
    // every step code on both sides, descriptor taken from memory
    for (int s = 0; s < 4; s++) begin
      put3(TBL + 32'h0000_0030, SE, DE, cw(2'(3 - s), 2'h0, 2'(s), 2'h0));
      wr(12'h000, m_a);
      wr(12'h004, m_b);
      wr(12'h008, m_c);
      wr(12'h014, 32'h0000_0005);
      settle();
      es = (s == 3) ? SE : SE - (32'h0000_0005 << s);
      ed = (s == 0) ? DE : DE - (32'h0000_0005 << (3 - s));
      ochk(cur_src_addr, es);
      ochk(cur_dst_addr, ed);
      ochk(32'(cfg_fault), 32'h0);
      rd(12'h018, es);
      rd(12'h01C, ed);
    end
    rd(12'h008, cw(2'h0, 2'h0, 2'h3, 2'h0));
    wr(12'h014, 32'h0);
    // every width code, word steps, last item
    for (int w = 0; w < 4; w++) begin
      wr(12'h008, cw(2'h2, 2'(w), 2'h2, 2'(w)));
      settle();
      ochk(32'(item_width), 32'(w));
      ochk(32'(cfg_fault), (w == 3) ? 32'hC : 32'h0);
      ochk(cur_src_addr, SE);
    end
    wr(12'h008, cw(2'h2, 2'h1, 2'h2, 2'h0));
    settle();
    ochk(32'(cfg_fault), 32'h2);
    wr(12'h008, cw(2'h2, 2'h2, 2'h0, 2'h2));
    wr(12'h000, 32'h0000_1000);
    rd(12'h024, 32'h0000_0005);
    apb(1'b1, 12'h018, 32'h1234_5678, 32'h0, 1'b1);
    apb(1'b1, 12'h030, 32'h1234_5678, 32'h0, 1'b1);
    apb(1'b0, 12'h030, 32'h0, 32'h0, 1'b1);
    rd(12'h018, 32'h0000_1000);
    give_verdict();
  end
endmodule : dma_channel_descriptor_decode_tb_top
